/* File: pkg/ofd_pkg.sv */
package ofd_pkg;

	// register byte offsets on the bus
	localparam logic [3:0] OFD_REG_BANK = 4'h0;
	localparam logic [3:0] OFD_REG_TBL_POINTER = 4'h4;
	localparam logic [3:0] OFD_REG_TBLLAT = 4'h8;
	localparam logic [3:0] OFD_REG_STATUS = 4'hc;

	// values after reset
	localparam logic [3:0] OFD_BANK_RST = 4'h0;
	localparam logic [20:0] OFD_TBL_POINTER_RST = 21'h000000;
	localparam logic [7:0] OFD_TBLLAT_RST = 8'h00;
	localparam logic [31:0] OFD_RDATA_RST = 32'h00000000;

	// access ram split: low part of bank 0 below, top of bank 15 above
	localparam logic [7:0] OFD_ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] OFD_ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] OFD_ACCESS_HIGH_BANK = 4'hf;
	// marker nibble of every second instruction word
	localparam logic [3:0] OFD_SECOND_MARK = 4'hf;

	typedef enum logic [1:0] {
		OFD_TBL_NONE = 2'b00,
		OFD_TBL_POSTINC = 2'b01,
		OFD_TBL_POSTDEC = 2'b10,
		OFD_TBL_PREINC = 2'b11
	} ofd_tbl_mode_t;

	typedef enum logic [1:0] {
		OFD_LIT_NONE = 2'b00,
		OFD_LIT_8 = 2'b01,
		OFD_LIT_12 = 2'b10,
		OFD_LIT_20 = 2'b11
	} ofd_lit_width_t;

	typedef enum logic [3:0] {
		OFD_K_NOP = 4'h0,
		OFD_K_BYTE = 4'h1,
		OFD_K_BIT = 4'h2,
		OFD_K_LIT = 4'h3,
		OFD_K_MOVE = 4'h4,
		OFD_K_INDEXED = 4'h5,
		OFD_K_TBLRD = 4'h6,
		OFD_K_TBLWR = 4'h7,
		OFD_K_CALL = 4'h8,
		OFD_K_GOTO = 4'h9,
		OFD_K_RETURN = 4'ha,
		OFD_K_BRANCH = 4'hb,
		OFD_K_LOADPTR = 4'hc,
		OFD_K_OTHER = 4'hd
	} ofd_kind_t;

	typedef enum logic [1:0] {
		OFD_ST_FIRST = 2'b00,
		OFD_ST_SECOND = 2'b01
	} ofd_state_t;

	typedef struct packed {
		ofd_kind_t kind;
		logic accessBank;
		logic destFile;
		logic writeAcc;
		logic writeFile;
		logic [2:0] bitSel;
		logic [7:0] bitMask;
		logic [7:0] fileAddr;
		logic [11:0] dataAddr;
		logic [1:0] ptrSel;
		logic [11:0] srcAddr;
		logic [11:0] dstAddr;
		logic [6:0] srcOff;
		logic [6:0] dstOff;
		logic [19:0] literal;
		ofd_lit_width_t litWidth;
		logic isRelative;
		logic [20:0] relOffset;
		logic [20:0] target;
		logic fastSel;
		logic shadowSave;
		logic shadowRestore;
		ofd_tbl_mode_t tblMode;
	} ofd_fields_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} ofd_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} ofd_wb_rsp_t;

endpackage

/* File: rtl/ofd_bank_addr.sv */
`timescale 1ns/1ps
module ofd_bank_addr #(
	parameter logic [7:0] ACCESS_SPLIT = ofd_pkg::OFD_ACCESS_SPLIT
)(
	// operand
	input wire logic accessBank,
	input wire logic [7:0] fileAddr,
	input wire logic [3:0] bankSel,
	// result
	output logic [11:0] dataAddr
);
	import ofd_pkg::*;

	always_comb
	begin
		if (accessBank)
			dataAddr = {bankSel, fileAddr};
		else if (fileAddr < ACCESS_SPLIT)
			dataAddr = {OFD_ACCESS_LOW_BANK, fileAddr};
		else
			dataAddr = {OFD_ACCESS_HIGH_BANK, fileAddr};
	end
endmodule

/* File: rtl/ofd_decoder.sv */
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module ofd_decoder #(
	parameter logic [7:0] ACCESS_SPLIT = ofd_pkg::OFD_ACCESS_SPLIT
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// instruction fetch
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	// decoded operands to the datapath
	output ofd_pkg::ofd_fields_t fields,
	output logic fieldsDone,
	// program memory table port
	output logic [20:0] tblAddr,
	output logic tblRead,
	output logic tblWrite,
	output logic [7:0] tblWrData,
	input wire logic tblRdValid,
	input wire logic [7:0] tblRdData,
	// register bus
	input wire ofd_pkg::ofd_wb_req_t wbReq,
	output ofd_pkg::ofd_wb_rsp_t wbRsp
);
	import ofd_pkg::*;

	if (ACCESS_SPLIT == 8'h00)
		$error("access split of zero leaves no low access region");

	// sign extension of a relative offset, used by both branch forms
	function automatic logic [20:0] relExt(input logic [10:0] v);
		relExt = {{10{v[10]}}, v};
	endfunction

	// byte lane merge for bus writes
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
			laneMerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	ofd_state_t state, next_state;
	ofd_fields_t next_fields;
	logic next_fieldsDone;
	logic [3:0] bankSel, next_bankSel;
	logic [20:0] table_pointer, next_table_pointer;
	logic [7:0] tableLatch, next_tableLatch;
	logic [20:0] next_tblAddr;
	logic next_tblRead, next_tblWrite;
	logic ack, next_ack;
	logic [31:0] rdDat, next_rdDat;
	logic [11:0] formedAddr;
	logic [7:0] maskBits;
	logic busWrite;
	logic [31:0] bankMerged, ptrMerged, latchMerged;

	// lane merge kept outside the process, as a function result cannot be part-selected
	assign bankMerged = laneMerge({28'h0000000, bankSel}, wbReq.dat, wbReq.sel);
	assign ptrMerged = laneMerge({11'h000, table_pointer}, wbReq.dat, wbReq.sel);
	assign latchMerged = laneMerge({24'h000000, tableLatch}, wbReq.dat, wbReq.sel);

	// bank and access region address former
	ofd_bank_addr #(
		.ACCESS_SPLIT(ACCESS_SPLIT)
	) u_bank_addr (
		.accessBank(next_fields.accessBank),
		.fileAddr(next_fields.fileAddr),
		.bankSel(bankSel),
		.dataAddr(formedAddr)
	);

	for (genvar g = 0; g < 8; g++)
	begin : g_mask
		assign maskBits[g] = (next_fields.bitSel == 3'(g));
	end

	// decode: first words start a field set, marked second words finish one
	always_comb
	begin
		next_state = state;
		next_fields = fields;
		next_fieldsDone = fieldsDone;
		if (instrValid)
		begin
			next_fieldsDone = 1'b1;
			next_state = OFD_ST_FIRST;
			if (state == OFD_ST_SECOND && instrWord[15:12] == OFD_SECOND_MARK)
			begin
				// unused bits of the second word are not looked at
				case (fields.kind)
					// destination address from the second word
					OFD_K_MOVE: next_fields.dstAddr = instrWord[11:0];
					OFD_K_INDEXED:
					begin
						if (fields.litWidth == OFD_LIT_NONE)
							next_fields.dstOff = instrWord[6:0];
						else
							next_fields.dstAddr = instrWord[11:0];
					end
					OFD_K_LOADPTR: next_fields.literal[7:0] = instrWord[7:0];
					OFD_K_CALL, OFD_K_GOTO:
					begin
						next_fields.literal[19:8] = instrWord[11:0];
						next_fields.target = {instrWord[11:0], fields.literal[7:0], 1'b0};
					end
					default: next_fields.kind = OFD_K_NOP;
				endcase
				next_fields.dataAddr = formedAddr;
				next_fields.bitMask = maskBits;
			end
			else
			begin
				next_fields = '0;
				next_fields.kind = OFD_K_OTHER;
				next_fields.accessBank = instrWord[8];
				next_fields.destFile = instrWord[9];
				next_fields.fileAddr = instrWord[7:0];
				// a marked word out of sequence does nothing
				if (instrWord[15:12] == OFD_SECOND_MARK)
					next_fields.kind = OFD_K_NOP;
				else if (instrWord[15:12] == 4'hc)
				begin
					// source address from the first word
					next_fields.kind = OFD_K_MOVE;
					next_fields.srcAddr = instrWord[11:0];
					next_state = OFD_ST_SECOND;
					next_fieldsDone = 1'b0;
				end
				else if (instrWord[15:12] == 4'h7 || instrWord[15:14] == 2'b10)
				begin
					// bit position in bits 11 to 9
					next_fields.kind = OFD_K_BIT;
					next_fields.bitSel = instrWord[11:9];
				end
				else if (instrWord[15:12] == 4'hd)
				begin
					next_fields.kind = OFD_K_BRANCH;
					next_fields.isRelative = 1'b1;
					next_fields.relOffset = relExt(instrWord[10:0]);
				end
				else if (instrWord[15:11] == 5'b11100)
				begin
					next_fields.kind = OFD_K_BRANCH;
					next_fields.isRelative = 1'b1;
					next_fields.relOffset = relExt({{3{instrWord[7]}}, instrWord[7:0]});
				end
				else if (instrWord[15:9] == 7'b1110110 || instrWord[15:8] == 8'hef)
				begin
					next_fields.kind = instrWord[9] ? OFD_K_GOTO : OFD_K_CALL;
					next_fields.fastSel = ~instrWord[9] & instrWord[8];
					next_fields.shadowSave = ~instrWord[9] & instrWord[8];
					next_fields.literal[7:0] = instrWord[7:0];
					next_fields.litWidth = OFD_LIT_20;
					next_state = OFD_ST_SECOND;
					next_fieldsDone = 1'b0;
				end
				else if (instrWord[15:6] == 10'b1110111000)
				begin
					// pointer select instead of file address
					next_fields.kind = OFD_K_LOADPTR;
					next_fields.ptrSel = instrWord[5:4];
					next_fields.literal[11:8] = instrWord[3:0];
					next_fields.litWidth = OFD_LIT_12;
					next_state = OFD_ST_SECOND;
					next_fieldsDone = 1'b0;
				end
				else if (instrWord[15:8] == 8'heb)
				begin
					// indexed source offset, destination form in bit 7
					next_fields.kind = OFD_K_INDEXED;
					next_fields.srcOff = instrWord[6:0];
					next_fields.litWidth = instrWord[7] ? OFD_LIT_NONE : OFD_LIT_12;
					next_state = OFD_ST_SECOND;
					next_fieldsDone = 1'b0;
				end
				else if (instrWord[15:3] == 13'h0001)
				begin
					// table access with mode in bits 1 and 0
					next_fields.kind = instrWord[2] ? OFD_K_TBLWR : OFD_K_TBLRD;
					next_fields.tblMode = ofd_tbl_mode_t'(instrWord[1:0]);
				end
				else if (instrWord[15:2] == 14'h0004)
				begin
					// fast bit restores shadows on return
					next_fields.kind = OFD_K_RETURN;
					next_fields.fastSel = instrWord[0];
					next_fields.shadowRestore = instrWord[0];
				end
				else if (instrWord[15:8] == 8'h01 || instrWord[15:11] == 5'b00001
					|| instrWord[15:12] == 4'he)
				begin
					next_fields.kind = OFD_K_LIT;
					next_fields.literal[7:0] = instrWord[7:0];
					next_fields.litWidth = OFD_LIT_8;
				end
				else if (instrWord[15:12] <= 4'h6 && instrWord[15:9] != 7'h00)
				begin
					// result to accumulator or file register
					next_fields.kind = OFD_K_BYTE;
					next_fields.writeFile = instrWord[9];
					next_fields.writeAcc = ~instrWord[9];
				end
				next_fields.dataAddr = formedAddr;
				next_fields.bitMask = maskBits;
			end
		end
	end

	// operand fields change only when a word is taken
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= OFD_ST_FIRST;
			fields <= '0;
			fieldsDone <= 1'b0;
		end
		else
		begin
			state <= next_state;
			fields <= next_fields;
			fieldsDone <= next_fieldsDone;
		end
	end

	// table pointer, latch and bus registers
	always_comb
	begin
		next_table_pointer = table_pointer;
		next_tableLatch = tableLatch;
		next_bankSel = bankSel;
		next_tblAddr = tblAddr;
		next_tblRead = 1'b0;
		next_tblWrite = 1'b0;
		next_ack = wbReq.cyc & wbReq.stb & ~ack;
		next_rdDat = rdDat;
		busWrite = wbReq.cyc & wbReq.stb & wbReq.we & ack;
		if (instrValid && next_fieldsDone
			&& (next_fields.kind == OFD_K_TBLRD || next_fields.kind == OFD_K_TBLWR))
		begin
			next_tblRead = (next_fields.kind == OFD_K_TBLRD);
			next_tblWrite = (next_fields.kind == OFD_K_TBLWR);
			next_tblAddr = table_pointer;
			case (next_fields.tblMode)
				OFD_TBL_POSTINC: next_table_pointer = table_pointer + 21'h000001;
				// post-decrement, or pre-increment before the access
				OFD_TBL_POSTDEC: next_table_pointer = table_pointer - 21'h000001;
				OFD_TBL_PREINC:
				begin
					next_table_pointer = table_pointer + 21'h000001;
					next_tblAddr = table_pointer + 21'h000001;
				end
				default: next_table_pointer = table_pointer;
			endcase
		end
		// a bus write lands on the ack edge and overrides a pointer step
		if (busWrite && wbReq.adr == OFD_REG_BANK)
			next_bankSel = bankMerged[3:0];
		if (busWrite && wbReq.adr == OFD_REG_TBL_POINTER)
			next_table_pointer = ptrMerged[20:0];
		if (busWrite && wbReq.adr == OFD_REG_TBLLAT)
			next_tableLatch = latchMerged[7:0];
		// program memory byte enters the 8-bit latch, wins over the bus
		if (tblRdValid)
			next_tableLatch = tblRdData;
		if (next_ack)
		begin
			case (wbReq.adr)
				OFD_REG_BANK: next_rdDat = {28'h0000000, bankSel};
				OFD_REG_TBL_POINTER: next_rdDat = {11'h000, table_pointer};
				OFD_REG_TBLLAT: next_rdDat = {24'h000000, tableLatch};
				OFD_REG_STATUS: next_rdDat = {24'h000000, 2'b00, state, fields.kind};
				default: next_rdDat = OFD_RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			table_pointer <= OFD_TBL_POINTER_RST;
			tableLatch <= OFD_TBLLAT_RST;
			bankSel <= OFD_BANK_RST;
			tblAddr <= OFD_TBL_POINTER_RST;
			tblRead <= 1'b0;
			tblWrite <= 1'b0;
			ack <= 1'b0;
			rdDat <= OFD_RDATA_RST;
		end
		else
		begin
			table_pointer <= next_table_pointer;
			tableLatch <= next_tableLatch;
			bankSel <= next_bankSel;
			tblAddr <= next_tblAddr;
			tblRead <= next_tblRead;
			tblWrite <= next_tblWrite;
			ack <= next_ack;
			rdDat <= next_rdDat;
		end
	end

	assign tblWrData = tableLatch;
	assign wbRsp.ack = ack;
	assign wbRsp.dat = rdDat;

	// checks on the decoded fields
	a_access_region: assert property (@(posedge clk) disable iff (!rst_n)
		(fields.kind == OFD_K_BYTE && !fields.accessBank)
		|-> fields.dataAddr[11:8] == ((fields.fileAddr < ACCESS_SPLIT) ? 4'h0 : 4'hf))
		else $error("access ram address formed from bank register");
	a_bank_form: assert property (@(posedge clk) disable iff (!rst_n)
		(instrValid && state == OFD_ST_FIRST && instrWord[15:12] == 4'h2 && instrWord[8])
		|=> fields.dataAddr == {$past(bankSel), $past(instrWord[7:0])})
		else $error("banked address does not use bank register");
	a_bit_pick: assert property (@(posedge clk) disable iff (!rst_n)
		fields.kind == OFD_K_BIT |-> fields.bitMask == (8'h01 << fields.bitSel))
		else $error("bit mask does not match bit field");
	a_dest_acc: assert property (@(posedge clk) disable iff (!rst_n)
		(instrValid && state == OFD_ST_FIRST && instrWord[15:10] == 6'b001001 && !instrWord[9])
		|=> fields.writeAcc && !fields.writeFile)
		else $error("clear destination bit did not target accumulator");
	a_dest_file: assert property (@(posedge clk) disable iff (!rst_n)
		fields.kind == OFD_K_BYTE && fields.destFile |-> fields.writeFile && !fields.writeAcc)
		else $error("set destination bit did not target file register");
	a_move_pair: assert property (@(posedge clk) disable iff (!rst_n)
		(instrValid && state == OFD_ST_SECOND && fields.kind == OFD_K_MOVE
			&& instrWord[15:12] == 4'hf)
		|=> fieldsDone && fields.kind == OFD_K_MOVE && fields.dstAddr == $past(instrWord[11:0])
			&& fields.srcAddr == $past(fields.srcAddr))
		else $error("two-word move destination not decoded");
	a_tbl_post: assert property (@(posedge clk) disable iff (!rst_n)
		(next_tblRead && next_fields.tblMode == OFD_TBL_POSTINC && !busWrite)
		|=> tblAddr == $past(table_pointer) && table_pointer == $past(table_pointer) + 21'h000001)
		else $error("post-increment table access wrong");
	a_tbl_pre: assert property (@(posedge clk) disable iff (!rst_n)
		(next_tblRead && next_fields.tblMode == OFD_TBL_PREINC && !busWrite)
		|=> tblAddr == table_pointer && table_pointer == $past(table_pointer) + 21'h000001)
		else $error("pre-increment table access wrong");
	a_shadow_fast: assert property (@(posedge clk) disable iff (!rst_n)
		!fields.fastSel |-> !fields.shadowSave && !fields.shadowRestore)
		else $error("shadow copies touched without fast bit");
	a_return_fast: assert property (@(posedge clk) disable iff (!rst_n)
		(instrValid && state == OFD_ST_FIRST && instrWord[15:1] == 15'h0009)
		|=> fields.shadowRestore == $past(instrWord[0]) && !fields.shadowSave)
		else $error("return fast bit not carried to shadow restore");
	a_lone_second: assert property (@(posedge clk) disable iff (!rst_n)
		(instrValid && state == OFD_ST_FIRST && instrWord[15:12] == 4'hf)
		|=> fields.kind == OFD_K_NOP && fieldsDone && !tblRead && !tblWrite)
		else $error("lone second word did not act as no-operation");
endmodule

/* File: testbench/ofd_prog_mem.sv */
`timescale 1ns/1ps
module ofd_prog_mem (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// table request from the decoder, read speed from the testbench
	input wire logic tblRead,
	input wire logic [20:0] tblAddr,
	input wire logic slow,
	// byte back to the table latch
	output logic tblRdValid,
	output logic [7:0] tblRdData
);
	logic busy;
	logic [2:0] delayCnt;
	logic [20:0] addr;
	// one byte per read
	// data is a pattern of the address; idle bus toggles so stale bytes never look valid
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			delayCnt <= 3'h0;
			addr <= 21'h000000;
			tblRdValid <= 1'b0;
			tblRdData <= 8'h00;
		end
		else
		begin
			tblRdValid <= 1'b0;
			if (tblRead)
			begin
				busy <= 1'b1;
				addr <= tblAddr;
				delayCnt <= slow ? 3'h3 : 3'h0;
			end
			else if (busy && delayCnt != 3'h0)
				delayCnt <= delayCnt - 3'h1;
			else if (busy)
			begin
				busy <= 1'b0;
				tblRdValid <= 1'b1;
				tblRdData <= addr[7:0] ^ 8'h5a;
			end
			else
				tblRdData <= ~tblRdData;
		end
	end
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import ofd_pkg::*;
	logic clk;
	logic rst_n;
	logic [15:0] instrWord;
	logic instrValid;
	ofd_fields_t fields;
	logic fieldsDone;
	logic [20:0] tblAddr;
	logic tblRead;
	logic tblWrite;
	logic [7:0] tblWrData;
	logic tblRdValid;
	logic [7:0] tblRdData;
	ofd_wb_req_t wbReq;
	ofd_wb_rsp_t wbRsp;
	logic slow;
	logic [31:0] rd;
	int nErrors = 0;
	int numChecks = 0;
	int cycles = 0;

	ofd_decoder ofd_decoder_i (.clk(clk), .rst_n(rst_n), .instrWord(instrWord),
		.instrValid(instrValid), .fields(fields), .fieldsDone(fieldsDone),
		.tblAddr(tblAddr), .tblRead(tblRead), .tblWrite(tblWrite), .tblWrData(tblWrData),
		.tblRdValid(tblRdValid), .tblRdData(tblRdData), .wbReq(wbReq), .wbRsp(wbRsp));
	ofd_prog_mem ofd_prog_mem_i (.clk(clk), .rst_n(rst_n), .tblRead(tblRead),
		.tblAddr(tblAddr), .slow(slow), .tblRdValid(tblRdValid), .tblRdData(tblRdData));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		numChecks++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// classic cycle: hold until ack is sampled, then release for a cycle
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		@(posedge clk);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
		@(posedge clk);
		while (wbRsp.ack !== 1'b1)
			@(posedge clk);
		rd = wbRsp.dat;
		wbReq.cyc <= 1'b0;
		wbReq.stb <= 1'b0;
	endtask

	// one word in; the word is scrambled afterwards so a late sample shows
	task automatic instr(input logic [15:0] w);
		@(posedge clk);
		instrWord <= w;
		instrValid <= 1'b1;
		@(posedge clk);
		instrValid <= 1'b0;
		instrWord <= ~w;
		#1;
	endtask

	task automatic t_reset();
		check(fieldsDone, 1'b0, "done");
		for (int i = 0; i < 16; i += 2)
		begin
			wb(1'b0, i[3:0], 32'h0);
			check(rd, 32'h0, "reset read");
		end
		$display("test reset done");
	endtask

	task automatic t_byte();
		wb(1'b1, OFD_REG_BANK, 32'h5);
		instr(16'h245f);
		check(fields.dataAddr, 12'h05f, "low access");
		check(fields.writeAcc, 1'b1, "acc");
		check(fields.writeFile, 1'b0, "file");
		instr(16'h2660);
		check(fields.dataAddr, 12'hf60, "high access");
		check(fields.writeFile, 1'b1, "file");
		check(fields.writeAcc, 1'b0, "acc");
		instr(16'h2560);
		check(fields.dataAddr, 12'h560, "banked");
		repeat (3) @(posedge clk);
		#1;
		check(fields.dataAddr, 12'h560, "held");
		check(fields.fileAddr, 8'h60, "file addr");
		$display("test byte done");
	endtask

	task automatic t_bits();
		for (int b = 0; b < 8; b++)
		begin
			instr(16'(16'h8033 | (b << 9)));
			check(fields.bitSel, b, "bit sel");
			check(fields.bitMask, 8'h01 << b, "bit mask");
		end
		$display("test bits done");
	endtask

	task automatic t_move();
		instr(16'hcfff);
		check(fieldsDone, 1'b0, "half");
		instr(16'hf000);
		check(fields.srcAddr, 12'hfff, "src");
		check(fields.dstAddr, 12'h000, "dst");
		check(fieldsDone, 1'b1, "whole");
		instr(16'hf456);
		check(fields.kind, OFD_K_NOP, "lone second");
		check(fieldsDone, 1'b1, "lone done");
		$display("test move done");
	endtask

	task automatic t_table(input logic [1:0] m, input logic [20:0] p, input logic [20:0] a,
		input logic [20:0] q, input logic s);
		@(posedge clk);
		slow <= s;
		wb(1'b1, OFD_REG_TBL_POINTER, {11'h0, p});
		instr(16'h0008 | m);
		check(tblRead, 1'b1, "read pulse");
		check(tblAddr, a, "table addr");
		check(fields.tblMode, m, "mode");
		wb(1'b0, OFD_REG_TBL_POINTER, 32'h0);
		check(rd, {11'h0, q}, "pointer");
		repeat (4) @(posedge clk);
		wb(1'b0, OFD_REG_TBLLAT, 32'h0);
		check(rd, {24'h0, a[7:0] ^ 8'h5a}, "latch");
		$display("test table mode %0d done", m);
	endtask

	task automatic t_write();
		wb(1'b1, OFD_REG_TBLLAT, 32'h3c);
		instr(16'h000c);
		check(tblWrite, 1'b1, "write pulse");
		check(tblWrData, 8'h3c, "write data");
		$display("test table write done");
	endtask

	task automatic t_ctrl();
		instr(16'hed34);
		instr(16'hf567);
		check(fields.target, 21'h0ace68, "call target");
		check(fields.shadowSave, 1'b1, "fast call");
		instr(16'hec34);
		instr(16'hf567);
		check(fields.shadowSave, 1'b0, "slow call");
		instr(16'h0013);
		check(fields.shadowRestore, 1'b1, "fast return");
		instr(16'h0012);
		check(fields.shadowRestore, 1'b0, "slow return");
		instr(16'hd7ff);
		check(fields.isRelative, 1'b1, "rel");
		check(fields.relOffset, 21'h1fffff, "bra offset");
		instr(16'he280);
		check(fields.relOffset, 21'h1fff80, "bc offset");
		instr(16'hef12);
		instr(16'hf345);
		check(fields.isRelative, 1'b0, "direct");
		check(fields.target, 21'h068a24, "goto target");
		check(fields.literal, 20'h34512, "20-bit");
		$display("test control done");
	endtask

	task automatic t_lit();
		instr(16'h0e9c);
		check(fields.literal, 20'h0009c, "k8");
		check(fields.litWidth, OFD_LIT_8, "w8");
		instr(16'hee2a);
		instr(16'hf0bc);
		check(fields.ptrSel, 2'h2, "ptr");
		check(fields.literal, 20'h00abc, "k12");
		check(fields.litWidth, OFD_LIT_12, "w12");
		for (int i = 0; i < 2; i++)
		begin
			instr(16'heb85);
			instr(i ? 16'hfffa : 16'hf07a);
			check(fields.srcOff, 7'h05, "src off");
			check(fields.dstOff, 7'h7a, "dst off");
		end
		instr(16'heb05);
		instr(16'hf123);
		check(fields.srcOff, 7'h05, "src off long");
		check(fields.dstAddr, 12'h123, "dst addr long");
		$display("test literal done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// a hang is cut well past the fewer than two hundred cycles the tests need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			nErrors++;
			$display("wrong value at %0t: timeout", $time);
			report_and_stop();
		end
	end

	initial
	begin
		rst_n = 1'b0;
		instrWord = 16'h0000;
		instrValid = 1'b0;
		wbReq = '0;
		slow = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_byte();
		t_bits();
		t_move();
		t_table(2'h0, 21'h000100, 21'h000100, 21'h000100, 1'b0);
		t_table(2'h1, 21'h1fffff, 21'h1fffff, 21'h000000, 1'b0);
		t_table(2'h2, 21'h000000, 21'h000000, 21'h1fffff, 1'b1);
		t_table(2'h3, 21'h0000ff, 21'h000100, 21'h000100, 1'b1);
		t_write();
		t_ctrl();
		t_lit();
		report_and_stop();
	end
endmodule
